// *** common/scc_pkg.sv ***
// package for the completion status coder: codes, events, states
package scc_pkg;
    localparam logic [3:0] GRP_DONE = 4'h1;
    localparam logic [3:0] GRP_PAUSE = 4'h2;
    localparam logic [3:0] Q_RESEL_OK = 4'h0;
    localparam logic [3:0] Q_SEL_OK = 4'h1;
    localparam logic [3:0] Q_XFER_NOATN = 4'h3;
    localparam logic [3:0] Q_XFER_ATN = 4'h4;
    localparam logic [3:0] Q_XLATE_OK = 4'h5;
    localparam logic [3:0] Q_SELXFER_OK = 4'h6;
    localparam logic [3:0] Q_MSGIN_PAUSE = 4'h0;
    localparam logic [3:0] Q_SAVE_PTR = 4'h1;
    localparam logic [3:0] Q_SEL_ABORT = 4'h2;
    localparam logic [3:0] Q_HALT_NOATN = 4'h3;
    localparam logic [3:0] Q_HALT_ATN = 4'h4;
    localparam logic [3:0] Q_RESEL_MISMATCH = 4'h7;
    localparam int PHASE_BIT = 3;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [2:0] ID_RST = 3'h0;
    localparam logic [2:0] LUN_RST = 3'h0;

    typedef enum logic [3:0] {
        EV_NONE = 4'h0,
        EV_RESEL_OK = 4'h1,
        EV_SEL_OK = 4'h2,
        EV_XFER_OK = 4'h3,
        EV_XLATE_OK = 4'h4,
        EV_SELXFER_OK = 4'h5,
        EV_TRANSFER_OK = 4'h6,
        EV_MSGIN_PAUSE = 4'h7,
        EV_SAVE_PTR = 4'h8,
        EV_SEL_ABORT = 4'h9,
        EV_HALT = 4'hA,
        EV_RESEL_CHECK = 4'hB,
        EV_TRANSFER_ABORT = 4'hC
    } scc_event_e;

    typedef enum logic [1:0] {
        ST_DISCONNECTED = 2'b00,
        ST_TARGET = 2'b01,
        ST_INITIATOR = 2'b10
    } scc_conn_e;
endpackage

// *** common/scc_code_if.sv ***
// carries an event to the encoder and the resulting code back
`timescale 1ns/100ps
`default_nettype none
interface scc_code_if;
    import scc_pkg::*;
    scc_event_e ev;
    logic atn;
    logic [2:0] phase;
    logic id_match;
    logic lun_match;
    logic valid;
    logic [7:0] code;
    modport enc (input ev, atn, phase, id_match, lun_match, output valid, code);
    modport top (output ev, atn, phase, id_match, lun_match, input valid, code);
endinterface
`default_nettype wire

// *** src/scc_encoder.sv ***
// maps a completion or pause event to its status code
`timescale 1ns/100ps
`default_nettype none
module scc_encoder
    import scc_pkg::*;
(
    scc_code_if.enc cif
);
    function automatic logic [7:0] mk(input logic [3:0] grp, input logic [3:0] q);
        mk = {grp, q};
    endfunction

    always_comb begin
        cif.valid = 1'b1;
        cif.code = STATUS_RST;
        case (cif.ev)
            // [RQ1] reselect done
            EV_RESEL_OK: cif.code = mk(GRP_DONE, Q_RESEL_OK);
            // [RQ2] select done
            EV_SEL_OK: cif.code = mk(GRP_DONE, Q_SEL_OK);
            // [RQ3] atn picks code
            EV_XFER_OK: cif.code = mk(GRP_DONE, cif.atn ? Q_XFER_ATN : Q_XFER_NOATN);
            // [RQ4] translate done
            EV_XLATE_OK: cif.code = mk(GRP_DONE, Q_XLATE_OK);
            // [RQ5] select and transfer
            EV_SELXFER_OK: cif.code = mk(GRP_DONE, Q_SELXFER_OK);
            // [RQ6] [RQ17] phase appended
            EV_TRANSFER_OK: cif.code = mk(GRP_DONE, {1'b1, cif.phase});
            // [RQ8] message in pause
            EV_MSGIN_PAUSE: cif.code = mk(GRP_PAUSE, Q_MSGIN_PAUSE);
            // [RQ9] save pointer pause
            EV_SAVE_PTR: cif.code = mk(GRP_PAUSE, Q_SAVE_PTR);
            // [RQ11] select aborted
            EV_SEL_ABORT: cif.code = mk(GRP_PAUSE, Q_SEL_ABORT);
            // [RQ12] halt with atn
            EV_HALT: cif.code = mk(GRP_PAUSE, cif.atn ? Q_HALT_ATN : Q_HALT_NOATN);
            // [RQ13] mismatch only
            EV_RESEL_CHECK: begin
                cif.valid = !(cif.id_match && cif.lun_match);
                cif.code = mk(GRP_PAUSE, Q_RESEL_MISMATCH);
            end
            // [RQ16] aborted transfer
            EV_TRANSFER_ABORT: cif.code = mk(GRP_PAUSE, {1'b1, cif.phase});
            // [RQ7] reserved never produced
            default: cif.valid = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// *** src/scc_status_coder.sv ***
// completion and pause status register with host interrupt request
// Notes on behaviour
// [RQ1] successful reselect reports 0x10 and becomes connected as target
// [RQ2] successful select reports 0x11 and becomes connected as initiator
// [RQ3] transfer-type command completion reports 0x13 without attention, 0x14 with
// [RQ4] translate address completion reports 0x15
// [RQ5] select-and-transfer completion reports 0x16
// [RQ6] transfer completion outside message-in reports 0x18 plus phase code
// [RQ7] reserved codes 0x12, 0x17, 0x25, 0x26 are never produced
// [RQ8] message-in pause keeps acknowledge asserted and reports 0x20
// [RQ9] save-data-pointer during select-and-transfer reports 0x21
// [RQ10] host should record its buffer pointer on 0x21 before resuming
// [RQ11] aborted select or reselect reports 0x22
// [RQ12] halted receive or send reports 0x23, or 0x24 with attention
// [RQ13] advanced mode reselect id or lun mismatch reports 0x27
// [RQ14] mismatch pause leaves acknowledge asserted
// [RQ15] mismatch pause stores peer id and logical unit
// [RQ16] aborted transfer reports 0x28 plus phase code
// [RQ17] phase code is message, control/data, input/output lines
// [RQ18] upper nibble is group, lower nibble qualifies
// [RQ19] status holds while request raised until read or reset
// [RQ20] request rises with latch and drops on status read
`timescale 1ns/100ps
`default_nettype none
module scc_status_coder
    import scc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [3:0] EVENT_CODE,
    input wire logic ATN,
    input wire logic MSG,
    input wire logic CD,
    input wire logic IO,
    input wire logic ADVANCED_MODE,
    input wire logic RESELECT_IDENTITY_CHECK_DISABLE,
    input wire logic [2:0] SELECTION_TARGET_REGISTER,
    input wire logic [2:0] LUN_PROGRAMMED,
    input wire logic [2:0] RESEL_ID,
    input wire logic [2:0] RESEL_LUN,
    input wire logic STATUS_READ,
    output logic [7:0] STATUS,
    output logic HOST_INTERRUPT_REQUEST,
    output logic ACK_HOLD,
    output logic [1:0] CONN_STATE,
    output logic [2:0] PEER_IDENTITY_REGISTER,
    output logic [2:0] LOGICAL_UNIT_REGISTER
);
    scc_code_if cif();

    // bus lines are asynchronous to CLK_SYS
    logic [3:0] bus_s1_r;
    logic [3:0] bus_s2_r;
    logic [3:0] bus_s1_nxt;
    logic [3:0] bus_s2_nxt;
    logic [2:0] bus_phase_code;
    logic bus_atn;

    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic irq_r;
    logic irq_nxt;
    logic ack_r;
    logic ack_nxt;
    scc_conn_e conn_r;
    scc_conn_e conn_nxt;
    logic [2:0] peer_r;
    logic [2:0] peer_nxt;
    logic [2:0] lun_r;
    logic [2:0] lun_nxt;
    logic check_on;
    logic new_code;

    always_comb begin
        bus_s1_nxt = {ATN, MSG, CD, IO};
        bus_s2_nxt = bus_s1_r;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            bus_s1_r <= 4'h0;
            bus_s2_r <= 4'h0;
        end else begin
            bus_s1_r <= bus_s1_nxt;
            bus_s2_r <= bus_s2_nxt;
        end
    end

    // [RQ17] phase from msg, c/d, i/o
    assign bus_phase_code = bus_s2_r[2:0];
    assign bus_atn = bus_s2_r[3];

    // identity check applies only in advanced mode with the check enabled
    assign check_on = ADVANCED_MODE && !RESELECT_IDENTITY_CHECK_DISABLE;

    always_comb begin
        cif.ev = scc_event_e'(EVENT_CODE);
        if (cif.ev == EV_RESEL_CHECK && !check_on) begin
            cif.ev = EV_NONE;
        end
        cif.atn = bus_atn;
        cif.phase = bus_phase_code;
        // [RQ13] compare against programmed values
        cif.id_match = (RESEL_ID == SELECTION_TARGET_REGISTER);
        cif.lun_match = (RESEL_LUN == LUN_PROGRAMMED);
    end

    scc_encoder u_enc (
        .cif(cif.enc)
    );

    // [RQ19] blocked while request pending
    assign new_code = cif.valid && !irq_r;

    always_comb begin
        status_nxt = status_r;
        irq_nxt = irq_r;
        ack_nxt = ack_r;
        conn_nxt = conn_r;
        peer_nxt = peer_r;
        lun_nxt = lun_r;
        // [RQ20] read drops request
        if (STATUS_READ) begin
            irq_nxt = 1'b0;
            ack_nxt = 1'b0;
        end
        if (new_code) begin
            // [RQ18] group and qualifier latched
            status_nxt = cif.code;
            // [RQ20] request raised with latch
            irq_nxt = 1'b1;
            case (cif.ev)
                // [RQ1] connected as target
                EV_RESEL_OK: conn_nxt = ST_TARGET;
                // [RQ2] connected as initiator
                EV_SEL_OK: conn_nxt = ST_INITIATOR;
                // [RQ8] hold acknowledge
                EV_MSGIN_PAUSE: ack_nxt = 1'b1;
                EV_RESEL_CHECK: begin
                    // [RQ14] hold acknowledge
                    ack_nxt = 1'b1;
                    // [RQ15] capture reselecting peer
                    peer_nxt = RESEL_ID;
                    lun_nxt = RESEL_LUN;
                    conn_nxt = ST_INITIATOR;
                end
                EV_SEL_ABORT: conn_nxt = ST_DISCONNECTED;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            status_r <= STATUS_RST;
            irq_r <= 1'b0;
            ack_r <= 1'b0;
            conn_r <= ST_DISCONNECTED;
            peer_r <= ID_RST;
            lun_r <= LUN_RST;
        end else begin
            status_r <= status_nxt;
            irq_r <= irq_nxt;
            ack_r <= ack_nxt;
            conn_r <= conn_nxt;
            peer_r <= peer_nxt;
            lun_r <= lun_nxt;
        end
    end

    assign STATUS = status_r;
    assign HOST_INTERRUPT_REQUEST = irq_r;
    assign ACK_HOLD = ack_r;
    assign CONN_STATE = conn_r;
    assign PEER_IDENTITY_REGISTER = peer_r;
    assign LOGICAL_UNIT_REGISTER = lun_r;

    a_status_held: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        irq_r && !STATUS_READ |=> $stable(status_r)) // [RQ19]
        else $error("status changed while request pending");

    a_irq_with_code: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        cif.valid && !irq_r |=> irq_r && status_r == $past(cif.code)) // [RQ20]
        else $error("request not raised with new code");

    a_irq_drop_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        irq_r && STATUS_READ |=> !irq_r) // [RQ20]
        else $error("request not dropped on read");

    a_no_reserved: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        status_r != 8'h12 && status_r != 8'h17 && status_r != 8'h25 && status_r != 8'h26) // [RQ7]
        else $error("reserved code produced");

    a_group_legal: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        irq_r |-> status_r[7:4] == GRP_DONE || status_r[7:4] == GRP_PAUSE) // [RQ18]
        else $error("bad status group");

    // attention is judged as the synchronised line stood at the taking edge
    a_xfer_atn_code: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RQ3]
        !irq_r && cif.ev == EV_XFER_OK |=> status_r == ($past(bus_atn) ? 8'h14 : 8'h13))
        else $error("transfer completion code wrong");

    a_phase_done: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !irq_r && cif.ev == EV_TRANSFER_OK |=> status_r == {5'b0001_1, $past(bus_phase_code)}) // [RQ6]
        else $error("transfer phase code wrong");

    a_phase_abort: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !irq_r && cif.ev == EV_TRANSFER_ABORT |=> status_r == {5'b0010_1, $past(bus_phase_code)}) // [RQ16]
        else $error("abort phase code wrong");

    a_mismatch_capture: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !irq_r && cif.ev == EV_RESEL_CHECK && cif.valid |=> ack_r && peer_r == $past(RESEL_ID)
        && lun_r == $past(RESEL_LUN) && status_r == 8'h27) // [RQ15]
        else $error("mismatch pause capture wrong");

    a_resel_target: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !irq_r && cif.ev == EV_RESEL_OK |=> status_r == 8'h10 && conn_r == ST_TARGET) // [RQ1]
        else $error("reselect completion wrong");

    a_sel_init: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !irq_r && cif.ev == EV_SEL_OK |=> status_r == 8'h11 && conn_r == ST_INITIATOR) // [RQ2]
        else $error("select completion wrong");

    a_msgin_ack: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !irq_r && cif.ev == EV_MSGIN_PAUSE |=> ack_r && status_r == 8'h20) // [RQ8]
        else $error("message in pause wrong");

    a_xlate_code: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RQ4]
        !irq_r && cif.ev == EV_XLATE_OK |=> status_r == 8'h15)
        else $error("translate completion wrong");

    a_selxfer_code: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RQ5]
        !irq_r && cif.ev == EV_SELXFER_OK |=> status_r == 8'h16)
        else $error("select and transfer completion wrong");

    a_save_ptr_code: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RQ9]
        !irq_r && cif.ev == EV_SAVE_PTR |=> status_r == 8'h21)
        else $error("save pointer pause wrong");

    a_sel_abort_code: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RQ11]
        !irq_r && cif.ev == EV_SEL_ABORT |=> status_r == 8'h22 && conn_r == ST_DISCONNECTED)
        else $error("select abort code wrong");

    a_halt_code: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RQ12]
        !irq_r && cif.ev == EV_HALT |=> status_r == ($past(bus_atn) ? 8'h24 : 8'h23))
        else $error("halt code wrong");

    // the raw event is watched, so a broken mode gate cannot hide behind cif.ev
    a_check_off: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RQ13]
        !irq_r && EVENT_CODE == 4'hB && !check_on |=> !irq_r)
        else $error("identity check raised request while off");
endmodule
`default_nettype wire

// *** tb/scc_host_model.sv ***
// host side model: reads the status register some cycles after the request rises
`timescale 1ns/100ps
`default_nettype none
module scc_host_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic irq,
    input wire logic [7:0] status,
    input wire logic [3:0] hold_cycles,
    output logic status_read,
    output logic [7:0] ptr_saves
);
    logic [3:0] wait_r;
    // a slow host leaves the request pending, so held status can be observed
    always @(posedge clk_sys) begin
        if (!rst_n || !irq || status_read) begin
            wait_r <= 4'h0;
            status_read <= 1'b0;
        end else if (wait_r == hold_cycles) begin
            status_read <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
            status_read <= 1'b0;
        end
    end
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ptr_saves <= 8'h00;
        end else if (status_read && status == 8'h21) begin
            ptr_saves <= ptr_saves + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** tb/scc_status_coder_tb.sv ***
// self-checking bench for the completion and pause status coder
`timescale 1ns/100ps
`default_nettype none
module scc_status_coder_tb;
    import scc_pkg::*;
    typedef struct packed {logic [3:0] ev; logic atn; logic [2:0] ph; logic [7:0] exp;} scc_row_s;
    logic clk_sys = 1'b0, rst_n = 1'b0, atn = 1'b0, idc_dis = 1'b0, status_read, irq, ack_hold;
    logic adv = 1'b1;
    logic [3:0] ev = 4'h0, hold = 4'h2;
    logic [2:0] ph = 3'h0, rid = 3'h0, rlun = 3'h0, peer, lunr;
    logic [7:0] status, ptr_saves;
    logic [1:0] conn;
    int errors = 0;
    int checks = 0;
    scc_row_s rows [11] = '{'{4'h1, 1'b0, 3'h0, 8'h10}, '{4'h2, 1'b0, 3'h0, 8'h11}, '{4'h3, 1'b0, 3'h0, 8'h13},
        '{4'h3, 1'b1, 3'h0, 8'h14}, '{4'h4, 1'b0, 3'h0, 8'h15}, '{4'h5, 1'b0, 3'h0, 8'h16},
        '{4'h7, 1'b0, 3'h7, 8'h20}, '{4'h8, 1'b0, 3'h0, 8'h21}, '{4'h9, 1'b0, 3'h0, 8'h22},
        '{4'hA, 1'b0, 3'h0, 8'h23}, '{4'hA, 1'b1, 3'h0, 8'h24}};

    always #50 clk_sys = ~clk_sys;

    scc_status_coder uut (.CLK_SYS(clk_sys), .RST_N(rst_n), .EVENT_CODE(ev), .ATN(atn), .MSG(ph[2]),
        .CD(ph[1]), .IO(ph[0]), .ADVANCED_MODE(adv), .RESELECT_IDENTITY_CHECK_DISABLE(idc_dis),
        .SELECTION_TARGET_REGISTER(3'h2), .LUN_PROGRAMMED(3'h1), .RESEL_ID(rid), .RESEL_LUN(rlun),
        .STATUS_READ(status_read), .STATUS(status), .HOST_INTERRUPT_REQUEST(irq), .ACK_HOLD(ack_hold),
        .CONN_STATE(conn), .PEER_IDENTITY_REGISTER(peer), .LOGICAL_UNIT_REGISTER(lunr));

    scc_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .irq(irq), .status(status), .hold_cycles(hold),
        .status_read(status_read), .ptr_saves(ptr_saves));

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // lines settle through the synchronisers before the event pulse
    task automatic fire(input logic [3:0] e, input logic a, input logic [2:0] p);
        @(posedge clk_sys);
        atn <= a;
        ph <= p;
        repeat (3) @(posedge clk_sys);
        ev <= e;
        @(posedge clk_sys);
        ev <= 4'h0;
        #1;
        chk("reserved", 8'h00, {7'h00, status inside {8'h12, 8'h17, 8'h25, 8'h26}});
    endtask

    task automatic drain;
        for (int i = 0; i < 40 && irq !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (irq !== 1'b0) begin
            errors++;
            $display("ERROR irq wait expected 0 seen %b", irq);
            tally_and_finish();
        end
        chk("ack cleared", 8'h00, {7'h00, ack_hold});
    endtask

    task automatic setr(input logic [2:0] id, input logic [2:0] lun, input logic dis, input logic [3:0] h);
        @(posedge clk_sys);
        rid <= id;
        rlun <= lun;
        idc_dis <= dis;
        hold <= h;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk("status rst", 8'h00, status);
        chk("irq rst", 8'h00, {7'h00, irq});
        foreach (rows[i]) begin
            fire(rows[i].ev, rows[i].atn, rows[i].ph);
            chk("status", rows[i].exp, status);
            chk("irq", 8'h01, {7'h00, irq});
            chk("ack", {7'h00, rows[i].ev == 4'h7}, {7'h00, ack_hold});
            if (rows[i].ev inside {4'h1, 4'h2}) begin
                chk("conn", {6'h00, rows[i].ev[1:0]}, {6'h00, conn});
            end
            drain();
        end
        chk("ptr saves", 8'h01, ptr_saves);
        for (int p = 0; p < 8; p++) begin
            fire(4'h6, 1'b0, 3'(p));
            chk("xfer done", {4'h1, 1'b1, 3'(p)}, status);
            drain();
            fire(4'hC, 1'b1, 3'(p));
            chk("xfer abort", {4'h2, 1'b1, 3'(p)}, status);
            drain();
        end
        setr(3'h5, 3'h1, 1'b0, 4'h2);
        fire(4'hB, 1'b0, 3'h0);
        chk("id mismatch", 8'h27, status);
        chk("mismatch ack", 8'h01, {7'h00, ack_hold});
        chk("peer id", 8'h05, {5'h00, peer});
        drain();
        setr(3'h2, 3'h6, 1'b0, 4'h2);
        fire(4'hB, 1'b0, 3'h0);
        chk("lun mismatch", 8'h27, status);
        chk("lun reg", 8'h06, {5'h00, lunr});
        drain();
        setr(3'h2, 3'h1, 1'b0, 4'h2);
        fire(4'hB, 1'b0, 3'h0);
        chk("match ignored", 8'h00, {7'h00, irq});
        setr(3'h5, 3'h6, 1'b1, 4'h2);
        fire(4'hB, 1'b0, 3'h0);
        chk("check off ignored", 8'h00, {7'h00, irq});
        setr(3'h5, 3'h6, 1'b0, 4'h2);
        adv <= 1'b0;
        fire(4'hB, 1'b0, 3'h0);
        chk("basic mode ignored", 8'h00, {7'h00, irq});
        fire(4'hD, 1'b0, 3'h0);
        chk("unknown ignored", 8'h00, {7'h00, irq});
        setr(3'h0, 3'h0, 1'b0, 4'hC);
        adv <= 1'b1;
        fire(4'h2, 1'b0, 3'h0);
        fire(4'h4, 1'b0, 3'h0);
        chk("held status", 8'h11, status);
        drain();
        setr(3'h0, 3'h0, 1'b0, 4'hF);
        fire(4'h1, 1'b0, 3'h0);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("status mid rst", 8'h00, status);
        chk("irq mid rst", 8'h00, {7'h00, irq});
        chk("conn mid rst", 8'h00, {6'h00, conn});
        tally_and_finish();
    end
endmodule
`default_nettype wire
